// ===== src/fp_pkg.sv
// Shared constants and carrier types for the front panel key handler
package fp_pkg;
  // --------------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 200_000_000;
  localparam int unsigned DEBOUNCE_US     = 20000;
  localparam int unsigned DEBOUNCE_CYC    = DEBOUNCE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SHOW_S          = 10;
  localparam longint unsigned SHOW_CYC    = longint'(SHOW_S) * CLK_HZ;
  localparam int unsigned DOUBLE_MS       = 500;
  localparam int unsigned DOUBLE_CYC      = DOUBLE_MS * (CLK_HZ / 1000);

  // --------------------------------------------------------------------------
  // Sizes and field values
  // --------------------------------------------------------------------------
  localparam int unsigned RD_W      = 24;
  localparam int unsigned NUM_SP    = 4;
  localparam int unsigned NUM_DIG   = 6;
  localparam int unsigned NUM_ITEMS = 16;
  localparam logic [3:0]  DIG_MAX   = 4'h9;
  localparam logic [3:0]  DIG_ZERO  = 4'h0;
  localparam logic [RD_W-1:0] PEAK_INIT   = {1'b1, {(RD_W-1){1'b0}}};
  localparam logic [RD_W-1:0] VALLEY_INIT = {1'b0, {(RD_W-1){1'b1}}};

  // --------------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_RUN = 2'b00,
    MODE_CFG = 2'b01,
    MODE_SP  = 2'b10
  } mode_t;

  typedef enum logic [1:0] {
    VIEW_LIVE   = 2'b00,
    VIEW_PEAK   = 2'b01,
    VIEW_VALLEY = 2'b10,
    VIEW_SP     = 2'b11
  } view_t;

  typedef struct packed {
    logic setpoint_recall_button;
    logic up_max;
    logic down_min;
    logic menu;
    logic reset_key;
  } keys_t;

  typedef struct packed {
    logic        store;
    logic [3:0]  item;
    logic [3:0]  digit_value;
    logic [2:0]  digit_pos;
    logic [3:0]  choice;
  } nvm_t;
endpackage

// ===== src/key_debounce.sv
// Debounces one push button and emits a one-cycle press pulse
`timescale 1ns/1ps
`default_nettype none
module key_debounce #(
  parameter int unsigned COUNT = fp_pkg::DEBOUNCE_CYC
) (
  // Clock, reset and enable
  input  wire logic sys_clk,
  input  wire logic resetn,
  input  wire logic clk_en,
  // Button
  input  wire logic raw,
  output logic      held,
  output logic      press
);
  localparam int unsigned CW = $clog2(COUNT + 1);
  if (COUNT < 1) begin : g_bad_count
    $error("COUNT must be at least one");
  end

  logic [CW-1:0] count;

  // Stable level must persist COUNT cycles before it is accepted
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      count <= '0;
      held  <= 1'b0;
      press <= 1'b0;
    end else if (clk_en) begin
      press <= 1'b0;
      if (raw == held) begin
        count <= '0;
      end else if (count == CW'(COUNT - 1)) begin
        count <= '0;
        held  <= raw;
        press <= raw;
      end else begin
        count <= count + 1'b1;
      end
    end
  end

  press_once_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (clk_en && press) |=> !press) else $error("press lasted more than one cycle");
endmodule
`default_nettype wire

// ===== src/front_panel_key_handler.sv
// Front panel key handler: modes, peak/valley, setpoint recall and editing
`timescale 1ns/1ps
`default_nettype none
module front_panel_key_handler #(
  parameter int unsigned     RD_W         = fp_pkg::RD_W,
  parameter int unsigned     DEBOUNCE_CYC = fp_pkg::DEBOUNCE_CYC,
  parameter longint unsigned SHOW_CYC     = fp_pkg::SHOW_CYC,
  parameter int unsigned     DOUBLE_CYC   = fp_pkg::DOUBLE_CYC
) (
  // Clock, reset, enable
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  input  wire logic              clk_en,
  // Buttons, raw levels
  input  wire fp_pkg::keys_t     keys_raw,
  // Measurement side
  input  wire logic              reading_valid,
  input  wire logic [RD_W-1:0]   reading,
  input  wire logic [3:0]        setpoint_state,
  input  wire logic              setpoints_unlocked,
  input  wire logic              item_is_binary,
  input  wire logic [3:0]        item_choice_count,
  // Display and control outputs
  output fp_pkg::mode_t          mode,
  output fp_pkg::view_t          view,
  output logic                   flash,
  output logic [RD_W-1:0]        peak,
  output logic [RD_W-1:0]        valley,
  output logic [1:0]             sp_index,
  output logic [3:0]             led,
  output logic                   measuring,
  output logic                   clear_latches,
  output logic                   clear_reading,
  output logic                   start_measure,
  output logic                   sp_store,
  output fp_pkg::nvm_t           nvm
);
  // --------------------------------------------------------------------------
  // Parameter checks
  // --------------------------------------------------------------------------
  localparam int unsigned SW = $clog2(SHOW_CYC + 1);
  localparam int unsigned DW = $clog2(DOUBLE_CYC + 1);
  if (RD_W != fp_pkg::RD_W || SHOW_CYC < 1 || DOUBLE_CYC < 1) begin : g_bad_param
    $error("unsupported width or timing count");
  end

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  // Decimal digit step with wrap, shared by config and setpoint edit
  function automatic logic [3:0] digit_inc(input logic [3:0] d);
    digit_inc = (d >= fp_pkg::DIG_MAX) ? fp_pkg::DIG_ZERO : d + 4'h1;
  endfunction
  function automatic logic [2:0] pos_right(input logic [2:0] p);
    pos_right = (p == 3'(fp_pkg::NUM_DIG - 1)) ? 3'h0 : p + 3'h1;
  endfunction

  // --------------------------------------------------------------------------
  // Button front end
  // --------------------------------------------------------------------------
  fp_pkg::keys_t held;
  fp_pkg::keys_t press;
  localparam int unsigned NK = $bits(fp_pkg::keys_t);

  for (genvar k = 0; k < NK; k++) begin : g_key
    key_debounce #(.COUNT(DEBOUNCE_CYC)) u_deb (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .clk_en  (clk_en),
      .raw     (keys_raw[k]),
      .held    (held[k]),
      .press   (press[k])
    );
  end

  // --------------------------------------------------------------------------
  // Reset key: single versus double press
  // --------------------------------------------------------------------------
  // A single press is only known once the window has expired, so it is late
  logic [DW-1:0] dbl_count;
  logic          dbl_armed;
  logic          rst_single;
  logic          rst_double;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      dbl_count  <= '0;
      dbl_armed  <= 1'b0;
      rst_single <= 1'b0;
      rst_double <= 1'b0;
    end else if (clk_en) begin
      rst_single <= 1'b0;
      rst_double <= 1'b0;
      if (press.reset_key && dbl_armed) begin
        dbl_armed  <= 1'b0;
        rst_double <= 1'b1;
      end else if (press.reset_key) begin
        dbl_armed <= 1'b1;
        dbl_count <= '0;
      end else if (dbl_armed && dbl_count == DW'(DOUBLE_CYC - 1)) begin
        dbl_armed  <= 1'b0;
        rst_single <= 1'b1;
      end else if (dbl_armed) begin
        dbl_count <= dbl_count + 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Mode and view
  // --------------------------------------------------------------------------
  logic [3:0] item;
  logic [3:0] digit_value;
  logic       digit_fresh;
  logic [2:0] digit_pos;
  logic [3:0] choice;
  logic [SW-1:0] show_count;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mode      <= fp_pkg::MODE_RUN;
      view      <= fp_pkg::VIEW_LIVE;
      measuring <= 1'b1;
    end else if (clk_en) begin
      case (mode)
        fp_pkg::MODE_RUN: begin
          if (press.menu) begin
            mode      <= fp_pkg::MODE_CFG;
            view      <= fp_pkg::VIEW_LIVE;
            measuring <= 1'b0;
          end else if (press.setpoint_recall_button && setpoints_unlocked) begin
            mode <= fp_pkg::MODE_SP;
            view <= fp_pkg::VIEW_SP;
          end else if (press.up_max) begin
            view <= (view == fp_pkg::VIEW_PEAK) ? fp_pkg::VIEW_LIVE : fp_pkg::VIEW_PEAK;
          end else if (press.down_min) begin
            view <= (view == fp_pkg::VIEW_VALLEY) ? fp_pkg::VIEW_LIVE : fp_pkg::VIEW_VALLEY;
          end else if (rst_single || rst_double) begin
            view <= fp_pkg::VIEW_LIVE;
          end
        end
        fp_pkg::MODE_CFG: begin
          if (rst_double) begin
            mode      <= fp_pkg::MODE_RUN;
            view      <= fp_pkg::VIEW_LIVE;
            measuring <= 1'b1;
          end
        end
        fp_pkg::MODE_SP: begin
          // Leaving after the last setpoint times out or on the menu key
          if (press.menu || (sp_index == 2'(fp_pkg::NUM_SP - 1) && !held.setpoint_recall_button
              && show_count == SW'(SHOW_CYC - 1) && !press.setpoint_recall_button)) begin
            mode <= fp_pkg::MODE_RUN;
            view <= fp_pkg::VIEW_LIVE;
          end
        end
        default: begin
          mode <= fp_pkg::MODE_RUN;
          view <= fp_pkg::VIEW_LIVE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      flash <= 1'b0;
    end else if (clk_en) begin
      flash <= (view == fp_pkg::VIEW_PEAK) || (view == fp_pkg::VIEW_VALLEY)
               || (mode != fp_pkg::MODE_RUN);
    end
  end

  // --------------------------------------------------------------------------
  // Peak and valley memories
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      peak   <= fp_pkg::PEAK_INIT;
      valley <= fp_pkg::VALLEY_INIT;
    end else if (clk_en) begin
      if (mode == fp_pkg::MODE_RUN && (rst_single || rst_double)) begin
        peak   <= fp_pkg::PEAK_INIT;
        valley <= fp_pkg::VALLEY_INIT;
      end else if (reading_valid && measuring) begin
        if ($signed(reading) > $signed(peak)) peak <= reading;
        if ($signed(reading) < $signed(valley)) valley <= reading;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      clear_latches <= 1'b0;
      clear_reading <= 1'b0;
      start_measure <= 1'b0;
    end else if (clk_en) begin
      clear_latches <= (mode == fp_pkg::MODE_RUN) && (rst_single || rst_double);
      clear_reading <= (mode == fp_pkg::MODE_RUN) && rst_double;
      start_measure <= ((mode == fp_pkg::MODE_RUN) && rst_double)
                       || ((mode == fp_pkg::MODE_CFG) && rst_double);
    end
  end

  // --------------------------------------------------------------------------
  // Setpoint recall and edit
  // --------------------------------------------------------------------------
  // Edits are saved on the next recall press, in the same cycle as the index advances
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sp_index   <= 2'h0;
      show_count <= '0;
      sp_store   <= 1'b0;
    end else if (clk_en) begin
      sp_store <= 1'b0;
      if (mode != fp_pkg::MODE_SP) begin
        sp_index   <= 2'h0;
        show_count <= '0;
      end else if (press.setpoint_recall_button) begin
        sp_store   <= 1'b1;
        sp_index   <= sp_index + 2'h1;
        show_count <= '0;
      end else if (held.setpoint_recall_button) begin
        show_count <= '0;
      end else if (show_count == SW'(SHOW_CYC - 1)) begin
        show_count <= '0;
        sp_index   <= sp_index + 2'h1;
      end else begin
        show_count <= show_count + 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Configuration and digit editing
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      item        <= 4'h0;
      digit_value <= fp_pkg::DIG_ZERO;
      digit_fresh <= 1'b1;
      digit_pos   <= 3'h0;
      choice      <= 4'h0;
    end else if (clk_en) begin
      if (mode == fp_pkg::MODE_RUN) begin
        item        <= 4'h0;
        digit_value <= fp_pkg::DIG_ZERO;
        digit_fresh <= 1'b1;
        digit_pos   <= 3'h0;
        choice      <= 4'h0;
      end else if (mode == fp_pkg::MODE_CFG) begin
        if (press.menu) begin
          item        <= item + 4'h1;
          digit_value <= fp_pkg::DIG_ZERO;
          digit_fresh <= 1'b1;
          choice      <= 4'h0;
        end else if (rst_single) begin
          item <= item - 4'h1;
        end else if (press.up_max && item_is_binary) begin
          choice <= {3'h0, ~choice[0]};
        end else if (press.up_max) begin
          digit_value <= digit_fresh ? fp_pkg::DIG_ZERO : digit_inc(digit_value);
          digit_fresh <= 1'b0;
        end else if (press.down_min) begin
          choice <= (choice + 4'h1 >= item_choice_count) ? 4'h0 : choice + 4'h1;
        end
      end else begin
        if (press.setpoint_recall_button) begin
          digit_value <= fp_pkg::DIG_ZERO;
          digit_pos   <= 3'h0;
        end else if (press.up_max) begin
          digit_value <= digit_inc(digit_value);
        end else if (press.down_min) begin
          digit_pos   <= pos_right(digit_pos);
          digit_value <= fp_pkg::DIG_ZERO;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      nvm <= '0;
    end else if (clk_en) begin
      nvm.store       <= (mode == fp_pkg::MODE_CFG) && press.menu;
      nvm.item        <= item;
      nvm.digit_value <= digit_value;
      nvm.digit_pos   <= digit_pos;
      nvm.choice      <= choice;
    end
  end

  // --------------------------------------------------------------------------
  // Indicators
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      led <= 4'h0;
    end else if (clk_en) begin
      led <= setpoint_state;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  sequence run_menu_s;
    clk_en && mode == fp_pkg::MODE_RUN && press.menu;
  endsequence
  recall_run_only_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (clk_en && mode == fp_pkg::MODE_CFG && press.setpoint_recall_button)
    |=> mode != fp_pkg::MODE_SP) else $error("recall acted outside run");
  recall_advance_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (clk_en && mode == fp_pkg::MODE_SP && press.setpoint_recall_button)
    |=> sp_store && sp_index == $past(sp_index) + 2'h1) else $error("recall did not advance");
  hold_pause_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (clk_en && mode == fp_pkg::MODE_SP && held.setpoint_recall_button && !press.menu
     && !press.setpoint_recall_button) |=> $stable(sp_index)) else $error("hold did not pause");
  peak_toggle_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (clk_en && mode == fp_pkg::MODE_RUN && !press.menu && !press.setpoint_recall_button
     && press.up_max && view == fp_pkg::VIEW_LIVE) |=> view == fp_pkg::VIEW_PEAK ##1 flash)
    else $error("peak view not entered");
  peak_track_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (clk_en && measuring && reading_valid && !rst_single && !rst_double
     && $signed(reading) > $signed(peak)) |=> peak == $past(reading)) else $error("peak lost");
  menu_enter_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    run_menu_s |=> mode == fp_pkg::MODE_CFG && !measuring && item == 4'h0)
    else $error("menu did not enter config");
  digit_wrap_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (clk_en && mode != fp_pkg::MODE_RUN && press.up_max && !press.setpoint_recall_button
     && !rst_single && !item_is_binary && digit_value == fp_pkg::DIG_MAX)
    |=> digit_value == fp_pkg::DIG_ZERO) else $error("digit did not wrap");
  double_reset_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (clk_en && mode == fp_pkg::MODE_RUN && rst_double) |=> clear_reading && start_measure
    && peak == fp_pkg::PEAK_INIT) else $error("hard reset incomplete");
  cfg_exit_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (clk_en && mode == fp_pkg::MODE_CFG && rst_double) |=> mode == fp_pkg::MODE_RUN && measuring)
    else $error("double reset did not leave config");
  led_follow_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    clk_en |=> led == $past(setpoint_state)) else $error("indicators lag");
endmodule
`default_nettype wire

// ===== verif/key_operator.sv
// Operator model that presses the front panel buttons with contact bounce
`timescale 1ns/1ps
`default_nettype none
module key_operator (
  // Clock
  input  wire logic         sys_clk,
  // Buttons, active high
  output var fp_pkg::keys_t keys_raw
);
  initial keys_raw = '0;

  // ----------------------------------------------------------------------
  // Press with bounce
  // ----------------------------------------------------------------------
  // Bounce is shorter than the debounce count, so it must not add presses.
  // The release gap lets the debouncer see the key up before the next push.
  task automatic push(input int k, input int hold);
    repeat (2) begin
      @(posedge sys_clk);
      #1 keys_raw[k] = ~keys_raw[k];
    end
    @(posedge sys_clk);
    #1 keys_raw[k] = 1'b1;
    repeat (hold) @(posedge sys_clk);
    #1 keys_raw[k] = 1'b0;
    repeat (5) @(posedge sys_clk);
    #1;
  endtask
endmodule
`default_nettype wire

// ===== verif/front_panel_key_handler_test.sv
// Self-checking bench for the front panel key handler
`timescale 1ns/1ps
`default_nettype none
module front_panel_key_handler_test;
  localparam int K_REC = 4, K_UP = 3, K_DN = 2, K_MENU = 1, K_RST = 0;
  logic sys_clk = 1'b0, resetn = 1'b0, clk_en = 1'b1;
  logic reading_valid = 1'b0, setpoints_unlocked = 1'b0, item_is_binary = 1'b0;
  logic [fp_pkg::RD_W-1:0] reading = '0, peak, valley;
  logic [3:0] setpoint_state = '0, item_choice_count = 4'h3, led, c;
  logic [2:0] p;
  logic [1:0] sp_index, s;
  logic flash, measuring, clear_latches, clear_reading, start_measure, sp_store;
  fp_pkg::keys_t keys_raw;
  fp_pkg::mode_t mode;
  fp_pkg::view_t view;
  fp_pkg::nvm_t nvm;
  logic signed [fp_pkg::RD_W-1:0] pk = fp_pkg::PEAK_INIT, vl = fp_pkg::VALLEY_INIT;
  logic [31:0] seed = 32'h9ED33490;
  int fail_count = 0, checks = 0, n_cl = 0, n_cr = 0, n_sm = 0, n_sp = 0, n_st = 0;
  int a, b;

  always #2.5 sys_clk = ~sys_clk;

  key_operator op_u (.sys_clk(sys_clk), .keys_raw(keys_raw));
  front_panel_key_handler #(.DEBOUNCE_CYC(4), .SHOW_CYC(50), .DOUBLE_CYC(20)) dut_u (
    .sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en), .keys_raw(keys_raw),
    .reading_valid(reading_valid), .reading(reading), .setpoint_state(setpoint_state),
    .setpoints_unlocked(setpoints_unlocked), .item_is_binary(item_is_binary),
    .item_choice_count(item_choice_count), .mode(mode), .view(view), .flash(flash),
    .peak(peak), .valley(valley), .sp_index(sp_index), .led(led), .measuring(measuring),
    .clear_latches(clear_latches), .clear_reading(clear_reading),
    .start_measure(start_measure), .sp_store(sp_store), .nvm(nvm));

  // ----------------------------------------------------------------------
  // Pulse counters
  // ----------------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (clear_latches === 1'b1) n_cl <= n_cl + 1;
    if (clear_reading === 1'b1) n_cr <= n_cr + 1;
    if (start_measure === 1'b1) n_sm <= n_sm + 1;
    if (sp_store === 1'b1) n_sp <= n_sp + 1;
    if (nvm.store === 1'b1) n_st <= n_st + 1;
  end

  // ----------------------------------------------------------------------
  // Helpers and reference model
  // ----------------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic test_done();
    if (fail_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input bit ok, input string msg);
    checks++;
    if (!ok) begin
      fail_count++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic push(input int k);
    op_u.push(k, 5);
  endtask
  // Single reset acts only after the double window closes
  task automatic wait_clear(input int n0);
    for (int i = 0; i < 40 && n_cl == n0; i++) tick(1);
    if (n_cl == n0) begin
      chk(1'b0, "single reset never acted");
      test_done();
    end
  endtask
  task automatic rd();
    logic signed [fp_pkg::RD_W-1:0] r;
    repeat (24) seed = lfsr(seed);
    r = seed[fp_pkg::RD_W-1:0];
    reading = r;
    setpoint_state = seed[27:24];
    reading_valid = 1'b1;
    tick(1);
    reading_valid = 1'b0;
    if (r > pk) pk = r;
    if (r < vl) vl = r;
    tick(2);
    chk(peak === pk && valley === vl, "peak valley");
    chk(led === setpoint_state, "indicators");
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    tick(3);
    resetn = 1'b1;
    chk(mode === fp_pkg::MODE_RUN && measuring === 1'b1, "reset state");
    repeat (20) rd();
    push(K_UP);
    chk(view === fp_pkg::VIEW_PEAK && flash === 1'b1, "peak view");
    repeat (3) rd();
    push(K_UP);
    chk(view === fp_pkg::VIEW_LIVE && peak === pk, "peak kept");
    push(K_DN);
    chk(view === fp_pkg::VIEW_VALLEY && flash === 1'b1, "valley view");
    repeat (3) rd();
    push(K_DN);
    chk(view === fp_pkg::VIEW_LIVE && valley === vl, "valley kept");
    push(K_REC);
    chk(mode === fp_pkg::MODE_RUN, "locked recall");
    setpoints_unlocked = 1'b1;
    push(K_REC);
    chk(mode === fp_pkg::MODE_SP && view === fp_pkg::VIEW_SP, "recall");
    c = nvm.digit_value;
    push(K_UP);
    chk(nvm.digit_value === (c + 4'h1) % 4'hA, "setpoint digit up");
    p = nvm.digit_pos;
    push(K_DN);
    chk(nvm.digit_pos === p + 3'h1, "setpoint digit right");
    s = sp_index;
    b = n_sp;
    push(K_REC);
    chk(n_sp == b + 1 && sp_index === s + 2'h1, "save and next");
    s = sp_index;
    tick(30);
    chk(sp_index === s, "early advance");
    tick(30);
    chk(sp_index === s + 2'h1, "auto advance");
    fork
      op_u.push(K_REC, 90);
      begin
        tick(12);
        s = sp_index;
        tick(70);
        chk(sp_index === s && mode === fp_pkg::MODE_SP, "held pause");
      end
    join
    push(K_MENU);
    chk(mode === fp_pkg::MODE_RUN, "back to run");
    b = n_cl;
    push(K_RST);
    wait_clear(b);
    pk = fp_pkg::PEAK_INIT;
    vl = fp_pkg::VALLEY_INIT;
    tick(3);
    chk(peak === pk && valley === vl && n_cr == 0, "single reset");
    repeat (5) rd();
    a = n_cr;
    b = n_sm;
    push(K_RST);
    push(K_RST);
    tick(25);
    pk = fp_pkg::PEAK_INIT;
    vl = fp_pkg::VALLEY_INIT;
    chk(n_cr == a + 1 && n_sm == b + 1, "hard reset");
    chk(peak === pk && valley === vl && mode === fp_pkg::MODE_RUN, "hard state");
    clk_en = 1'b0;
    push(K_UP);
    clk_en = 1'b1;
    chk(view === fp_pkg::VIEW_LIVE && flash === 1'b0, "enable low froze keys");
    push(K_RST);
    tick(25);
    push(K_RST);
    tick(25);
    chk(n_cr == a + 1, "slow presses are singles");
    push(K_MENU);
    chk(mode === fp_pkg::MODE_CFG && measuring === 1'b0, "enter config");
    push(K_REC);
    chk(mode === fp_pkg::MODE_CFG, "recall ignored");
    c = nvm.item;
    b = n_st;
    push(K_MENU);
    chk(n_st == b + 1 && nvm.item === c + 4'h1, "store and next");
    for (int i = 0; i < 11; i++) begin
      push(K_UP);
      chk(nvm.digit_value === 4'(i % 10), "digit wrap");
    end
    item_is_binary = 1'b1;
    push(K_UP);
    c = nvm.choice;
    push(K_UP);
    chk(c < 4'h2 && nvm.choice === 4'h1 - c, "binary toggle");
    item_is_binary = 1'b0;
    c = nvm.choice;
    push(K_DN);
    chk(nvm.choice === (c + 4'h1) % 4'h3, "choice step");
    c = nvm.item;
    push(K_RST);
    tick(25);
    chk(nvm.item === c - 4'h1 && mode === fp_pkg::MODE_CFG, "step back");
    push(K_RST);
    push(K_RST);
    tick(25);
    chk(mode === fp_pkg::MODE_RUN && measuring === 1'b1, "leave config");
    test_done();
  end
endmodule
`default_nettype wire
